// ### core/poll_pkg.sv
// Shared types and constants for the polled pin event logic
package poll_pkg;
  localparam int          NUM_PINS      = 16;
  localparam int          PIN_IDX_W     = 4;
  localparam int          MODE_W        = 4;
  localparam int          SLOT_W        = 3;
  localparam int          STATUS_W      = 8;
  localparam int          STATUS_BASE   = 128;
  localparam int          STATUS_WORDS  = 8;
  localparam int          STATUS_IDX_W  = 3;
  localparam logic [2:0]  MODE_OFF_CLR  = 3'h0;
  localparam logic [2:0]  MODE_OFF_KEEP = 3'h1;
  localparam logic [2:0]  MODE_OUT      = 3'h2;
  localparam logic [2:0]  MODE_RUN      = 3'h3;
  localparam logic [2:0]  MODE_OUT_RUN  = 3'h4;
  localparam logic [2:0]  MODE_CLR_IN   = 3'h5;
  localparam logic [2:0]  MODE_CLR_OUT  = 3'h6;
  localparam logic [2:0]  MODE_CLR_ALL  = 3'h7;
  localparam int          LATCH_BIT     = 3;
  localparam logic [15:0] PINS_ZERO     = 16'h0000;

  typedef enum logic [2:0] {
    CMD_NONE,
    CMD_WATCH,
    CMD_DRIVE,
    CMD_MODE,
    CMD_PIN_WRITE,
    CMD_RUN_SLOT
  } cmd_e;

  typedef struct packed {
    cmd_e                  cmd;
    logic [PIN_IDX_W-1:0]  pin;
    logic                  level;
    logic [MODE_W-1:0]     mode;
    logic [SLOT_W-1:0]     slot;
  } poll_cmd_s;

  typedef struct packed {
    logic                  run_go;
    logic [SLOT_W-1:0]     run_slot;
    logic                  wait_release;
  } poll_act_s;
endpackage

// ### core/polled_pin_event_logic.sv
// Background pin polling: watched inputs, driven outputs, mode control
module polled_pin_event_logic
  import poll_pkg::*;
#(
  parameter int PINS = NUM_PINS
)(
  input  wire logic                    mclk,
  input  wire logic                    rst,
  input  wire poll_cmd_s               cmd,
  input  wire logic                    cmd_valid,
  input  wire logic                    insn_boundary,
  input  wire logic                    wait_active,
  input  wire logic [PINS-1:0]         pin_in,
  input  wire logic [STATUS_IDX_W-1:0] status_addr,
  output logic      [PINS-1:0]         pin_out,
  output logic      [PINS-1:0]         pin_oe,
  output logic      [STATUS_W-1:0]     status_rdata,
  output poll_act_s                    act,
  output logic                         polling_on
);

  logic [PINS-1:0]     watch_en_r;
  logic [PINS-1:0]     watch_lvl_r;
  logic [PINS-1:0]     drive_en_r;
  logic [PINS-1:0]     drive_lvl_r;
  logic [MODE_W-1:0]   mode_r;
  logic [SLOT_W-1:0]   slot_r;
  logic [PINS-1:0]     sync1_r;
  logic [PINS-1:0]     sync2_r;
  logic [PINS-1:0]     sync3_r;
  logic [PINS-1:0]     pin_stable_r;
  logic [PINS-1:0]     hit_r;
  logic [STATUS_W-1:0] status_mem [STATUS_WORDS];
  logic [PINS-1:0]     match_vec;
  logic                any_match;
  logic [2:0]          base_mode;
  logic                latched;
  logic                out_action;
  logic                run_action;
  logic                active;
  logic                is_clear;

  assign base_mode  = mode_r[2:0];
  assign latched    = mode_r[LATCH_BIT];
  assign active     = (base_mode == MODE_OUT) || (base_mode == MODE_RUN) ||
                      (base_mode == MODE_OUT_RUN);
  assign out_action = (base_mode == MODE_OUT) || (base_mode == MODE_OUT_RUN);
  assign run_action = (base_mode == MODE_RUN) || (base_mode == MODE_OUT_RUN);
  assign is_clear   = cmd.mode[2:0] >= MODE_CLR_IN;

  // Three stages; second and third must agree, first is never looked at
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      sync1_r      <= PINS_ZERO[PINS-1:0];
      sync2_r      <= PINS_ZERO[PINS-1:0];
      sync3_r      <= PINS_ZERO[PINS-1:0];
      pin_stable_r <= PINS_ZERO[PINS-1:0];
    end
    else
    begin
      sync1_r      <= pin_in;
      sync2_r      <= sync1_r;
      sync3_r      <= sync2_r;
      // Agreeing stages load their level; disagreeing ones keep the old one
      pin_stable_r <= (pin_stable_r & (sync2_r ^ sync3_r)) | (sync2_r & sync3_r);
    end
  end

  generate
    for (genvar i = 0; i < PINS; i++)
    begin : g_match
      assign match_vec[i] = watch_en_r[i] & (pin_stable_r[i] == watch_lvl_r[i]);
    end
  endgenerate

  assign any_match = |match_vec;

  // Watched and driven configuration, kept until cleared by mode
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      watch_en_r  <= PINS_ZERO[PINS-1:0];
      watch_lvl_r <= PINS_ZERO[PINS-1:0];
      drive_en_r  <= PINS_ZERO[PINS-1:0];
      drive_lvl_r <= PINS_ZERO[PINS-1:0];
      slot_r      <= '0;
    end
    else if (cmd_valid)
    begin
      unique case (cmd.cmd)
        CMD_WATCH:
        begin
          watch_en_r[cmd.pin]  <= 1'b1;
          watch_lvl_r[cmd.pin] <= cmd.level;
        end
        CMD_DRIVE:
        begin
          drive_en_r[cmd.pin]  <= 1'b1;
          drive_lvl_r[cmd.pin] <= cmd.level;
        end
        CMD_RUN_SLOT:
          slot_r <= cmd.slot;
        CMD_MODE:
        begin
          if (cmd.mode[2:0] == MODE_OFF_CLR || cmd.mode[2:0] == MODE_CLR_IN ||
              cmd.mode[2:0] == MODE_CLR_ALL)
            watch_en_r <= PINS_ZERO[PINS-1:0];
          if (cmd.mode[2:0] == MODE_OFF_CLR || cmd.mode[2:0] == MODE_CLR_OUT ||
              cmd.mode[2:0] == MODE_CLR_ALL)
            drive_en_r <= PINS_ZERO[PINS-1:0];
        end
        default:
        begin
        end
      endcase
    end
  end

  // Mode register; clear modes leave the previous mode in force
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      mode_r <= '0;
    else if (cmd_valid && cmd.cmd == CMD_MODE && !is_clear)
      mode_r <= cmd.mode;
    else if (active && run_action && insn_boundary && any_match)
      mode_r <= {mode_r[LATCH_BIT],
                 (base_mode == MODE_RUN) ? MODE_OFF_KEEP : MODE_OUT};
  end

  // Pin direction and level; program writes override latched state
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      pin_out <= PINS_ZERO[PINS-1:0];
      pin_oe  <= PINS_ZERO[PINS-1:0];
    end
    else
    begin
      if (cmd_valid && cmd.cmd == CMD_WATCH)
        pin_oe[cmd.pin] <= 1'b0;
      else if (cmd_valid && cmd.cmd == CMD_DRIVE)
        pin_oe[cmd.pin] <= 1'b1;
      else if (cmd_valid && cmd.cmd == CMD_PIN_WRITE)
      begin
        pin_oe[cmd.pin]  <= 1'b1;
        pin_out[cmd.pin] <= cmd.level;
      end
      else if (active && out_action && insn_boundary)
      begin
        for (int i = 0; i < PINS; i++)
        begin
          if (drive_en_r[i])
          begin
            if (any_match)
              pin_out[i] <= drive_lvl_r[i];
            else if (!latched)
              pin_out[i] <= ~drive_lvl_r[i];
          end
        end
      end
    end
  end

  // Latched hit bits for status; sticky until mode 0 clears them
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      hit_r <= PINS_ZERO[PINS-1:0];
    else if (cmd_valid && cmd.cmd == CMD_MODE && cmd.mode[2:0] == MODE_OFF_CLR)
      hit_r <= (active && insn_boundary) ? match_vec : PINS_ZERO[PINS-1:0];
    else if (active && insn_boundary)
      hit_r <= hit_r | match_vec;
  end

  // Status words in scratchpad order starting at the base location
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      for (int w = 0; w < STATUS_WORDS; w++)
        status_mem[w] <= '0;
    end
    else
    begin
      status_mem[0] <= hit_r[7:0];
      status_mem[1] <= hit_r[15:8];
      status_mem[2] <= {mode_r, 1'b0, slot_r};
      status_mem[3] <= pin_stable_r[7:0];
      status_mem[4] <= pin_stable_r[15:8];
      status_mem[5] <= '0;
      status_mem[6] <= '0;
      status_mem[7] <= '0;
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      status_rdata <= '0;
    else
      status_rdata <= status_mem[status_addr];
  end

  // Action pulses toward the instruction sequencer
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      act        <= '0;
      polling_on <= 1'b0;
    end
    else
    begin
      act.run_go       <= active && run_action && insn_boundary && any_match;
      act.run_slot     <= slot_r;
      act.wait_release <= active && out_action && wait_active && any_match;
      polling_on       <= active;
    end
  end

endmodule

// ### test/pin_loads.sv
// Switches with pull-ups and indicator loads on the sixteen pins
module pin_loads (
  input  wire logic [15:0] sw_level,
  input  wire logic [15:0] pin_out,
  input  wire logic [15:0] pin_oe,
  output wire logic [15:0] pin_lvl
);
  timeunit 1ns;
  timeprecision 1ps;
  // Driven pins override the switch; released ones rest at the switch level
  assign pin_lvl = (pin_oe & pin_out) | (~pin_oe & sw_level);
endmodule

// ### test/poll_props.sv
// Port checker for the polled pin event logic
module poll_props
  import poll_pkg::*;
#(
  parameter int PINS = NUM_PINS
)(
  input wire logic                    mclk,
  input wire logic                    rst,
  input wire poll_cmd_s               cmd,
  input wire logic                    cmd_valid,
  input wire logic                    insn_boundary,
  input wire logic                    wait_active,
  input wire logic [PINS-1:0]         pin_in,
  input wire logic [STATUS_IDX_W-1:0] status_addr,
  input wire logic [PINS-1:0]         pin_out,
  input wire logic [PINS-1:0]         pin_oe,
  input wire logic [STATUS_W-1:0]     status_rdata,
  input wire poll_act_s               act,
  input wire logic                    polling_on
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  AST_WATCH_IN: assert property (cmd_valid && cmd.cmd == CMD_WATCH |=>
    !pin_oe[$past(cmd.pin)]) else $error("watched pin still driven");
  AST_DRIVE_OUT: assert property (cmd_valid && cmd.cmd == CMD_DRIVE |=>
    pin_oe[$past(cmd.pin)]) else $error("driven pin not enabled");
  // Three idle cycles so the registered mode has surely settled
  AST_IDLE_HOLD: assert property ((!cmd_valid && !polling_on)[*3] ##0 insn_boundary
    |=> $stable(pin_out)) else $error("outputs moved while polling off");
  AST_BOUND_ONLY: assert property (!insn_boundary && !cmd_valid |=> $stable(pin_out))
    else $error("outputs moved without boundary");
  AST_CFG_KEEP: assert property (!cmd_valid |=> $stable(pin_oe))
    else $error("pin direction lost");
  AST_RUN_PULSE: assert property (act.run_go |=> !act.run_go)
    else $error("run start longer than one cycle");
  AST_MODE_ON: assert property (cmd_valid && cmd.cmd == CMD_MODE &&
    cmd.mode[2:0] == MODE_OUT ##1 !cmd_valid |=> polling_on) else $error("polling not active");
  AST_MODE_OFF: assert property (cmd_valid && cmd.cmd == CMD_MODE && cmd.mode == 4'h0
    ##1 !cmd_valid |=> !polling_on) else $error("polling not stopped");
  AST_STATUS_ZERO: assert property ($past(status_addr) >= 3'h5 |-> status_rdata == 8'h00)
    else $error("unused status word not zero");
endmodule

bind polled_pin_event_logic poll_props #(.PINS(PINS)) poll_props_i (.mclk, .rst, .cmd,
  .cmd_valid, .insn_boundary, .wait_active, .pin_in, .status_addr, .pin_out, .pin_oe,
  .status_rdata, .act, .polling_on);

// ### test/tb.sv
// Self-checking bench for the polled pin event logic
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin errors++; \
  $display("mismatch t=%0t got=%0h exp=%0h", $time, a, b); end end
module tb import poll_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk = 1'h0, rst = 1'h1, cmd_valid = 1'h0, insn_boundary = 1'h0;
  logic        wait_active = 1'h0, polling_on;
  logic [15:0] sw_level = 16'hFFFF, pin_lvl, pin_out, pin_oe, lv;
  logic [2:0]  status_addr = 3'h0;
  logic [7:0]  status_rdata;
  poll_cmd_s   cmd = '0;
  poll_act_s   act;
  int          errors = 0, num_checks = 0;
  polled_pin_event_logic polled_pin_event_logic_i (.mclk, .rst, .cmd, .cmd_valid,
    .insn_boundary, .wait_active, .pin_in(pin_lvl), .status_addr, .pin_out, .pin_oe,
    .status_rdata, .act, .polling_on);
  pin_loads pin_loads_i (.sw_level, .pin_out, .pin_oe, .pin_lvl);
  initial
    forever #4 mclk = ~mclk;
  task automatic tick(int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic issue(cmd_e c, logic [3:0] p, logic l, logic [3:0] m);
    cmd = '{c, p, l, m, 3'h5};
    cmd_valid = 1'h1;
    tick(1);
    cmd_valid = 1'h0;
    tick(1);
  endtask
  // Switch edges pass a filter of a few cycles before a boundary may see them
  task automatic step(int settle);
    tick(settle);
    insn_boundary = 1'h1;
    tick(1);
    insn_boundary = 1'h0;
    tick(2);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic t_setup();
    issue(CMD_WATCH, 4'h0, 1'h0, 4'h0);
    issue(CMD_WATCH, 4'hF, 1'h0, 4'h0);
    issue(CMD_DRIVE, 4'h1, 1'h1, 4'h0);
    issue(CMD_DRIVE, 4'h2, 1'h0, 4'h0);
    `CHK(pin_oe[15], 1'h0)
    `CHK(pin_oe[2:0], 3'h6)
    sw_level[0] = 1'h0;
    lv = pin_out;
    step(8);
    `CHK(pin_out, lv)
    $display("test setup done");
  endtask
  task automatic t_track();
    issue(CMD_MODE, 4'h0, 1'h0, 4'h2);
    for (int k = 0; k < 4; k++)
    begin
      sw_level[0] = k[0];
      sw_level[15] = k[1];
      step(8);
      `CHK(pin_out[2:1], (k == 3) ? 2'h2 : 2'h1)
    end
    `CHK(polling_on, 1'h1)
    $display("test track done");
  endtask
  task automatic t_latch();
    issue(CMD_MODE, 4'h0, 1'h0, 4'hA);
    sw_level[0] = 1'h0;
    step(8);
    `CHK(pin_out[2:1], 2'h1)
    sw_level[0] = 1'h1;
    step(8);
    `CHK(pin_out[2:1], 2'h1)
    issue(CMD_PIN_WRITE, 4'h1, 1'h0, 4'h0);
    step(1);
    `CHK(pin_out[1], 1'h0)
    `CHK(pin_oe[2:0], 3'h6)
    $display("test latch done");
  endtask
  task automatic t_run();
    issue(CMD_MODE, 4'h0, 1'h0, 4'h0);
    status_addr = 3'h5;
    tick(2);
    `CHK(polling_on, 1'h0)
    `CHK(status_rdata, 8'h00)
    issue(CMD_WATCH, 4'h3, 1'h1, 4'h0);
    issue(CMD_RUN_SLOT, 4'h0, 1'h0, 4'h0);
    wait_active = 1'h1;
    issue(CMD_MODE, 4'h0, 1'h0, 4'h4);
    insn_boundary = 1'h1;
    for (int n = 0; n < 8 && act.run_go !== 1'h1; n++)
    begin
      tick(1);
      insn_boundary = 1'h0;
    end
    `CHK(act.run_go, 1'h1)
    if (act.run_go !== 1'h1)
      return;
    `CHK(act.run_slot, 3'h5)
    `CHK(act.wait_release, 1'h1)
    wait_active = 1'h0;
    status_addr = 3'h2;
    tick(3);
    `CHK(status_rdata, 8'h25)
    `CHK(act.wait_release, 1'h0)
    $display("test run done");
  endtask
  initial
  begin
    tick(4);
    rst = 1'h0;
    tick(1);
    t_setup();
    t_track();
    t_latch();
    t_run();
    conclude();
  end
endmodule
